// File: src/pdcs_consts.vh
// Constants for the device control / status register bank.
// Assumes inclusion by the bank module only; plain Verilog-2005.
`ifndef PDCS_CONSTS_VH
`define PDCS_CONSTS_VH

// ==========================================================
// Register byte addresses
`define PDCS_OFS_DEVICE_CONTROL 12'h048
`define PDCS_OFS_DEVICE_STATUS  12'h04a
`define PDCS_ADDR_CTLSTS        12'h048
`define PDCS_ADDR_IRQ_STATUS    12'h100
`define PDCS_ADDR_IRQ_MASK      12'h104

// ==========================================================
// Control fields
`define PDCS_CTL_REPORT_LSB     0
`define PDCS_CTL_RELAXED_BIT    4
`define PDCS_CTL_MPS_LSB        5
`define PDCS_CTL_WIDE_TAG_BIT   8
`define PDCS_CTL_PHANTOM_BIT    9
`define PDCS_CTL_AUX_PWR_BIT    10
`define PDCS_CTL_NO_SNOOP_BIT   11
`define PDCS_CTL_RRS_LSB        12

// ==========================================================
// Status fields
`define PDCS_STS_ERR_LSB        0
`define PDCS_STS_AUX_BIT        4
`define PDCS_STS_PENDING_BIT    5

// ==========================================================
// Codes and reset values
`define PDCS_MPS_256            3'h1
`define PDCS_PAYLOAD_128        12'h080
`define PDCS_PAYLOAD_256        12'h100
`define PDCS_TAG_MAX_NARROW     8'h1f
`define PDCS_TAG_MAX_WIDE       8'hff
`define PDCS_RESET_4            4'h0
`define PDCS_RESET_3            3'h0

`endif

// File: src/pdcs_regs.v
// Device control and device status register bank with APB slave.
// Assumes error detect pulses and aux power level from other clock
// domains or pins; all are synchronised here before use.
`timescale 1ns/1ns
`include "pdcs_consts.vh"

module pdcs_regs (
	// Clock and resets
	input  wire        clock_in,
	input  wire        nrst_in,
	input  wire        aux_por_n_in,
	// APB slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	// Error detect pulses, aux power level and sequential tag debug mode
	input  wire [3:0]  err_detect_in,
	input  wire        aux_power_in,
	input  wire        sequential_tag_debug_in,
	// Report requests, steering outputs and interrupt
	output reg  [3:0]  report_req_out,
	output reg  [11:0] max_payload_bytes_out,
	output reg  [7:0]  tag_max_out,
	output reg         relaxed_order_attr_out,
	output reg         no_snoop_attr_out,
	output reg         irq_out
);

	// ==========================================================
	// Input synchronisers
	reg  [3:0]  err_s1_r;
	reg  [3:0]  err_s2_r;
	reg  [3:0]  err_s3_r;
	reg         aux_s1_r;
	reg         aux_s2_r;
	reg         dbg_s1_r;
	reg         dbg_s2_r;
	wire [3:0]  err_event;

	always @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			err_s1_r <= `PDCS_RESET_4;
			err_s2_r <= `PDCS_RESET_4;
			err_s3_r <= `PDCS_RESET_4;
			aux_s1_r <= 1'b0;
			aux_s2_r <= 1'b0;
			dbg_s1_r <= 1'b0;
			dbg_s2_r <= 1'b0;
		end else begin
			err_s1_r <= err_detect_in;
			err_s2_r <= err_s1_r;
			err_s3_r <= err_s2_r;
			aux_s1_r <= aux_power_in;
			aux_s2_r <= aux_s1_r;
			dbg_s1_r <= sequential_tag_debug_in;
			dbg_s2_r <= dbg_s1_r;
		end
	end

	// Rising edge only; a held level counts as one event
	assign err_event = err_s2_r & ~err_s3_r;

	// ==========================================================
	// APB decode
	wire        acc    = psel_in & penable_in;
	// Writes land only at the edge where ready is sampled high
	wire        wr     = acc & pwrite_in & pready_out;
	wire        hit_cs = (paddr_in == `PDCS_ADDR_CTLSTS);
	wire        hit_is = (paddr_in == `PDCS_ADDR_IRQ_STATUS);
	wire        hit_im = (paddr_in == `PDCS_ADDR_IRQ_MASK);
	wire        mapped = hit_cs | hit_is | hit_im;

	// ==========================================================
	// Control register
	reg  [3:0]  report_en_r;
	reg  [2:0]  mps_r;
	reg         wide_tag_r;
	reg         aux_en_r;
	reg  [3:0]  err_seen_r;
	reg  [3:0]  irq_sts_r;
	reg  [3:0]  irq_mask_r;

	always @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			report_en_r <= `PDCS_RESET_4;
			mps_r       <= `PDCS_RESET_3;
			wide_tag_r  <= 1'b0;
		end else if (wr && hit_cs) begin
			report_en_r <= pwdata_in[`PDCS_CTL_REPORT_LSB +: 4];
			mps_r       <= pwdata_in[`PDCS_CTL_MPS_LSB +: 3];
			wide_tag_r  <= pwdata_in[`PDCS_CTL_WIDE_TAG_BIT];
		end
	end

	// Sticky: only aux power-on reset clears it, not core resets
	always @(posedge clock_in or negedge aux_por_n_in) begin
		if (!aux_por_n_in) begin
			aux_en_r <= 1'b0;
		end else if (wr && hit_cs) begin
			aux_en_r <= pwdata_in[`PDCS_CTL_AUX_PWR_BIT];
		end
	end

	// ==========================================================
	// Status flags: set wins over write-one clear
	wire [3:0]  sts_clr  = (wr && hit_cs) ? pwdata_in[16 +: 4] : 4'h0;
	wire [3:0]  irq_clr  = (wr && hit_is) ? pwdata_in[3:0] : 4'h0;

	always @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			err_seen_r <= `PDCS_RESET_4;
			irq_sts_r  <= `PDCS_RESET_4;
			irq_mask_r <= `PDCS_RESET_4;
		end else begin
			err_seen_r <= (err_seen_r & ~sts_clr) | err_event;
			irq_sts_r  <= (irq_sts_r & ~irq_clr) | err_event;
			if (wr && hit_im) begin
				irq_mask_r <= pwdata_in[3:0];
			end
		end
	end

	// ==========================================================
	// Read data assembly
	wire [15:0] ctl_word = {1'b0, 3'h0, 1'b0, aux_en_r, 1'b0, wide_tag_r, mps_r, 1'b0, report_en_r};
	wire [15:0] sts_word = {10'h000, 1'b0, aux_s2_r, err_seen_r};
	reg  [31:0] rdata;

	always @* begin
		rdata = 32'h00000000;
		if (hit_cs) begin
			rdata = {sts_word, ctl_word};
		end else if (hit_is) begin
			rdata = {28'h0000000, irq_sts_r};
		end else if (hit_im) begin
			rdata = {28'h0000000, irq_mask_r};
		end
	end

	// ==========================================================
	// Outputs, all registered
	always @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prdata_out             <= 32'h00000000;
			pready_out             <= 1'b0;
			pslverr_out            <= 1'b0;
			report_req_out         <= `PDCS_RESET_4;
			max_payload_bytes_out  <= `PDCS_PAYLOAD_128;
			tag_max_out            <= `PDCS_TAG_MAX_NARROW;
			relaxed_order_attr_out <= 1'b0;
			no_snoop_attr_out      <= 1'b0;
			irq_out                <= 1'b0;
		end else begin
			// One wait state: ready rises in second access cycle
			pready_out     <= acc & ~pready_out;
			pslverr_out    <= acc & ~pready_out & ~mapped;
			prdata_out     <= (acc & ~pready_out & ~pwrite_in) ? rdata : 32'h00000000;
			report_req_out <= err_event & report_en_r;
			if (mps_r == `PDCS_MPS_256) begin
				max_payload_bytes_out <= `PDCS_PAYLOAD_256;
			end else begin
				max_payload_bytes_out <= `PDCS_PAYLOAD_128;
			end
			// Tag range only matters in sequential tag debug mode
			if (dbg_s2_r && wide_tag_r) begin
				tag_max_out <= `PDCS_TAG_MAX_WIDE;
			end else begin
				tag_max_out <= `PDCS_TAG_MAX_NARROW;
			end
			relaxed_order_attr_out <= 1'b0;
			no_snoop_attr_out      <= 1'b0;
			irq_out                <= |(irq_sts_r & irq_mask_r);
		end
	end

endmodule

// File: test/pdcs_regs_properties.sv
// Port checker for the control/status bank.
// Assumes bind onto pdcs_regs, one clock domain.
`timescale 1ns/1ns
module pdcs_chk (
	input wire logic        clock_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out,
	input wire logic        relaxed_order_attr_out, no_snoop_attr_out, sequential_tag_debug_in,
	input wire logic [11:0] paddr_in, max_payload_bytes_out,
	input wire logic [31:0] prdata_out,
	input wire logic [3:0]  report_req_out,
	input wire logic [7:0]  tag_max_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	a_answer_next: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("ready late");
	a_ready_single: assert property (pready_out |=> !pready_out)
		else $error("ready held");
	a_idle_rdata: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("read data idle");
	a_refusal_shape: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
		else $error("bad refusal");
	a_fixed_zero: assert property (pready_out && paddr_in == 12'h048 |-> (prdata_out & 32'hffe0fa10) == 32'h0)
		else $error("fixed bits set");
	a_attr_clear: assert property (!relaxed_order_attr_out && !no_snoop_attr_out)
		else $error("attribute set");
	a_payload_code: assert property (max_payload_bytes_out == 12'h100 || max_payload_bytes_out == 12'h080)
		else $error("payload value");
	a_narrow_tag: assert property (!sequential_tag_debug_in [*5] |-> tag_max_out == 8'h1f)
		else $error("tag range");
	a_report_pulse: assert property (report_req_out != 4'h0 |=> (report_req_out & $past(report_req_out)) == 4'h0)
		else $error("report held");
	cover property (pslverr_out);
	cover property (report_req_out != 4'h0);
	cover property (tag_max_out == 8'hff);
endmodule
bind pdcs_regs pdcs_chk u_chk (.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .pready_out(pready_out), .pslverr_out(pslverr_out), .paddr_in(paddr_in),
	.relaxed_order_attr_out(relaxed_order_attr_out), .no_snoop_attr_out(no_snoop_attr_out),
	.sequential_tag_debug_in(sequential_tag_debug_in), .max_payload_bytes_out(max_payload_bytes_out),
	.prdata_out(prdata_out), .report_req_out(report_req_out), .tag_max_out(tag_max_out));

// File: test/testbench.sv
// Self-checking bench for the control/status bank.
// Assumes pdcs_regs and its checker compiled first.
`timescale 1ns/1ns
module testbench;
	logic        clock_in = 0, nrst_in = 0, aux_por_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic        aux_power_in = 0, sequential_tag_debug_in = 0, e;
	logic        pready_out, pslverr_out, irq_out;
	logic [11:0] paddr_in = 0;
	logic [11:0] mp_out;
	logic [31:0] pwdata_in = 0, rd, lf = 32'ha6c719a3;
	logic [31:0] prdata_out;
	logic [3:0]  err_detect_in = 0, seen = 0;
	logic [3:0]  report_req_out;
	logic [7:0]  tag_out;
	int          n_mismatch = 0, checked = 0;
	pdcs_regs dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .aux_por_n_in(aux_por_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .err_detect_in(err_detect_in),
		.aux_power_in(aux_power_in), .sequential_tag_debug_in(sequential_tag_debug_in), .irq_out(irq_out),
		.report_req_out(report_req_out), .max_payload_bytes_out(mp_out), .tag_max_out(tag_out),
		.relaxed_order_attr_out(), .no_snoop_attr_out());
	initial forever #4 clock_in = ~clock_in;
	// Sticky record, so one-cycle pulses are never missed
	always @(posedge clock_in) seen <= seen | report_req_out;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic close_out;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in) penable_in <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clock_in);
			if (pready_out === 1'b1) break;
		end
		if (i == 20) n_mismatch++;
		if (i == 20) close_out();
		rd = prdata_out;
		e = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
		@(posedge clock_in);
	endtask
	initial begin
		repeat (4) @(posedge clock_in);
		nrst_in <= 1;
		aux_por_n_in <= 1;
		apb(0, 12'h048, 0);
		cmp("reset word", 0, rd);
		for (int k = 0; k < 8; k++) begin
			lf = lfsr(lf);
			apb(1, 12'h048, (lf & 32'hffffff1f) | (k << 5));
			apb(0, 12'h048, 0);
			cmp("control", (lf & 32'h0000050f) | (k << 5), rd);
			cmp("payload", (k == 1) ? 12'h100 : 12'h080, mp_out);
		end
		apb(0, 12'h200, 0);
		cmp("slverr", 1, e);
		apb(1, 12'h048, 32'h5);
		apb(1, 12'h104, 32'h7);
		for (int k = 0; k < 4; k++) begin
			err_detect_in[k] <= 1;
			repeat (8) @(posedge clock_in);
			err_detect_in[k] <= 0;
			apb(0, 12'h048, 0);
			cmp("err flag", 32'h5 | (32'h10000 << k), rd);
			cmp("irq", k != 3, irq_out);
			apb(1, 12'h048, 32'h5 | (32'h10000 << k));
			apb(1, 12'h100, 32'hf);
			apb(0, 12'h048, 0);
			cmp("cleared", 32'h5, rd);
			cmp("irq off", 0, irq_out);
		end
		cmp("reports", 32'h5, seen);
		aux_power_in <= 1;
		sequential_tag_debug_in <= 1;
		apb(1, 12'h048, 32'h500);
		apb(0, 12'h048, 0);
		cmp("aux", 32'h100500, rd);
		cmp("tag", 8'hff, tag_out);
		nrst_in <= 0;
		repeat (2) @(posedge clock_in);
		nrst_in <= 1;
		repeat (4) @(posedge clock_in);
		apb(0, 12'h048, 0);
		cmp("sticky", 32'h100400, rd);
		close_out();
	end
endmodule
